// >>> hw/nibble_swap_and_direction_load.sv
`timescale 1ns/1ns
// What this block does
// - Nibble exchange result puts file bits 3..0 high and bits 7..4 low.
// - Destination bit zero: result goes to accumulator, file register untouched.
// - Destination bit one: result is written back to the addressed file register.
// - Direction load takes operand 5, 6 or 7 from low three instruction bits.
// - Direction load copies the whole accumulator into the selected direction register.
module nibble_swap_and_direction_load
  import nibble_dir_pkg::*;
(
  // Clock and reset
  input  wire logic                                      i_clk,
  input  wire logic                                      i_rstn,
  // Instruction issue
  input  wire logic                                      i_insn_valid,
  input  wire logic [nibble_dir_pkg::INSN_W-1:0]         i_insn,
  // File register read data for the addressed register
  input  wire logic [nibble_dir_pkg::DATA_W-1:0]         i_file_rdata,
  // File register write back
  output logic                                           o_file_we,
  output logic      [nibble_dir_pkg::FADDR_W-1:0]        o_file_addr,
  output logic      [nibble_dir_pkg::DATA_W-1:0]         o_file_wdata,
  // Accumulator and direction registers
  output logic      [nibble_dir_pkg::DATA_W-1:0]         o_w,
  output logic      [nibble_dir_pkg::NUM_DIR*nibble_dir_pkg::DATA_W-1:0] o_dir,
  // Status
  output logic                                           o_done,
  output logic                                           o_illegal
);

  import nibble_dir_pkg::*;

  logic [DATA_W-1:0]     w_q;
  logic [DATA_W-1:0]     dir_q [NUM_DIR];
  logic [DATA_W-1:0]     swapped;
  logic                  dest_to_file;
  logic [PORT_SEL_W-1:0] dir_sel;
  logic                  dir_sel_ok;
  op_kind_t              op_kind;

  nibble_exchanger u_swap (
    .i_data (i_file_rdata),
    .o_data (swapped)
  );

  assign dest_to_file = i_insn[DEST_BIT];
  assign dir_sel      = i_insn[PORT_SEL_W-1:0];
  assign dir_sel_ok   = (dir_sel >= DIR_SEL_FIRST) && (dir_sel <= DIR_SEL_LAST);

  always_comb begin
    op_kind = OP_NONE;
    if (i_insn_valid && ((i_insn & SWAP_MASK) == SWAP_MATCH)) begin
      op_kind = OP_SWAP;
    end else if (i_insn_valid && ((i_insn & DIR_MASK) == DIR_MATCH)) begin
      op_kind = OP_DIR;
    end
  end

  // Accumulator: only the swap with destination zero writes it
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      w_q <= W_RESET;
    end else if (op_kind == OP_SWAP && !dest_to_file) begin
      w_q <= swapped;
    end
  end

  // File write back, one cycle after issue
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_file_we    <= 1'b0;
      o_file_addr  <= '0;
      o_file_wdata <= '0;
    end else begin
      o_file_we    <= (op_kind == OP_SWAP) && dest_to_file;
      o_file_addr  <= i_insn[FADDR_W-1:0];
      o_file_wdata <= swapped;
    end
  end

  // Direction registers; operands outside 5..7 are dropped and flagged
  for (genvar g = 0; g < NUM_DIR; g++) begin : g_dir
    // Operand that selects this lane: lanes follow the operand order upward
    localparam logic [PORT_SEL_W-1:0] LANE_SEL = PORT_SEL_W'(DIR_SEL_FIRST + PORT_SEL_W'(g));

    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        dir_q[g] <= DIR_RESET;
      end else if (op_kind == OP_DIR && dir_sel_ok &&
                   dir_sel == LANE_SEL) begin
        dir_q[g] <= w_q;
      end
    end
    assign o_dir[g*DATA_W +: DATA_W] = dir_q[g];

    property p_dir_lane_load;
      @(posedge i_clk) disable iff (!i_rstn)
      (op_kind == OP_DIR && dir_sel == LANE_SEL) |=> dir_q[g] == $past(w_q);
    endproperty
    a_dir_lane_load: assert property (p_dir_lane_load)
      else $error("selected direction register not loaded");

    // A lane that was not named keeps its value
    property p_dir_lane_hold;
      @(posedge i_clk) disable iff (!i_rstn)
      (op_kind != OP_DIR || dir_sel != LANE_SEL) |=> $stable(dir_q[g]);
    endproperty
    a_dir_lane_hold: assert property (p_dir_lane_hold)
      else $error("unselected direction register changed");
  end

  // Completion: every recognised instruction retires the cycle after issue; a bad direction operand also raises o_illegal
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
    end else begin
      o_done    <= (op_kind != OP_NONE);
      o_illegal <= (op_kind == OP_DIR) && !dir_sel_ok;
    end
  end

  assign o_w = w_q;

  // Assertions
  sequence s_swap_w;
    i_insn_valid && ((i_insn & SWAP_MASK) == SWAP_MATCH) && !i_insn[DEST_BIT];
  endsequence

  sequence s_swap_f;
    i_insn_valid && ((i_insn & SWAP_MASK) == SWAP_MATCH) && i_insn[DEST_BIT];
  endsequence

  property p_swap_order;
    @(posedge i_clk) disable iff (!i_rstn)
    s_swap_w |=> o_w == {$past(i_file_rdata[NIB_W-1:0]),
                         $past(i_file_rdata[DATA_W-1:NIB_W])};
  endproperty
  a_swap_order: assert property (p_swap_order)
    else $error("swap result bits misplaced");

  property p_swap_to_w;
    @(posedge i_clk) disable iff (!i_rstn)
    s_swap_w |=> !o_file_we;
  endproperty
  a_swap_to_w: assert property (p_swap_to_w)
    else $error("file written when destination is accumulator");

  property p_swap_to_f;
    @(posedge i_clk) disable iff (!i_rstn)
    s_swap_f |=> o_file_we && o_file_wdata == {$past(i_file_rdata[NIB_W-1:0]),
                  $past(i_file_rdata[DATA_W-1:NIB_W])} && $stable(o_w);
  endproperty
  a_swap_to_f: assert property (p_swap_to_f)
    else $error("swap write back wrong");

  property p_dir_bad;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_DIR && !dir_sel_ok) |=> o_illegal && $stable(o_dir);
  endproperty
  a_dir_bad: assert property (p_dir_bad)
    else $error("bad direction operand was accepted");

  property p_dir_load;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_DIR && dir_sel == DIR_SEL_FIRST) |=> o_dir[DATA_W-1:0] == $past(o_w);
  endproperty
  a_dir_load: assert property (p_dir_load)
    else $error("direction register not loaded from accumulator");

  property p_one_cycle;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind != OP_NONE) |=> o_done;
  endproperty
  a_one_cycle: assert property (p_one_cycle)
    else $error("instruction did not retire in one cycle");

  // Words the decoder does not know must leave every output idle except o_file_addr and o_file_wdata
  property p_idle_quiet;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_NONE) |=> !o_done && !o_file_we && !o_illegal &&
                             $stable(o_w) && $stable(o_dir);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("unrecognised word changed an output");

  property p_swap_f_addr;
    @(posedge i_clk) disable iff (!i_rstn)
    s_swap_f |=> o_file_addr == $past(i_insn[FADDR_W-1:0]);
  endproperty
  a_swap_f_addr: assert property (p_swap_f_addr)
    else $error("swap write back went to the wrong file address");

  property p_swap_keeps_dir;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_SWAP) |=> $stable(o_dir) && !o_illegal && o_done;
  endproperty
  a_swap_keeps_dir: assert property (p_swap_keeps_dir)
    else $error("swap disturbed direction registers");

  property p_dir_keeps_w;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_DIR) |=> $stable(o_w) && !o_file_we;
  endproperty
  a_dir_keeps_w: assert property (p_dir_keeps_w)
    else $error("direction load disturbed accumulator or file");

  property p_dir_good;
    @(posedge i_clk) disable iff (!i_rstn)
    (op_kind == OP_DIR && dir_sel_ok) |=> !o_illegal;
  endproperty
  a_dir_good: assert property (p_dir_good)
    else $error("legal direction operand was flagged");

  // Write strobe only ever follows a swap aimed at the file
  property p_we_from_swap;
    @(posedge i_clk) disable iff (!i_rstn)
    o_file_we |-> $past(op_kind == OP_SWAP && dest_to_file);
  endproperty
  a_we_from_swap: assert property (p_we_from_swap)
    else $error("file write without a swap to file");

  property p_illegal_from_dir;
    @(posedge i_clk) disable iff (!i_rstn)
    o_illegal |-> $past(op_kind == OP_DIR && !dir_sel_ok);
  endproperty
  a_illegal_from_dir: assert property (p_illegal_from_dir)
    else $error("illegal flag without a bad direction operand");

endmodule

// >>> hw/nibble_dir_pkg.sv
package nibble_dir_pkg;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned INSN_W     = 12;
  localparam int unsigned FADDR_W    = 5;
  localparam int unsigned NIB_W      = 4;
  localparam int unsigned PORT_SEL_W = 3;
  localparam int unsigned NUM_DIR    = 3;

  // Opcode patterns: nibble exchange 0011_10df_ffff, direction load 0000_0000_0fff
  localparam logic [INSN_W-1:0] SWAP_MASK  = 12'h0FC0;
  localparam logic [INSN_W-1:0] SWAP_MATCH = 12'h0380;
  localparam logic [INSN_W-1:0] DIR_MASK   = 12'h0FF8;
  localparam logic [INSN_W-1:0] DIR_MATCH  = 12'h0000;

  localparam int unsigned DEST_BIT = 5;

  localparam logic [PORT_SEL_W-1:0] DIR_SEL_FIRST = 3'h5;
  localparam logic [PORT_SEL_W-1:0] DIR_SEL_LAST  = 3'h7;

  localparam logic [DATA_W-1:0] W_RESET   = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RESET = 8'hFF;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_SWAP,
    OP_DIR
  } op_kind_t;

endpackage

// >>> hw/nibble_exchanger.sv
`timescale 1ns/1ns
module nibble_exchanger
  import nibble_dir_pkg::*;
(
  input  wire logic [nibble_dir_pkg::DATA_W-1:0] i_data,
  output logic      [nibble_dir_pkg::DATA_W-1:0] o_data
);

  assign o_data = {i_data[NIB_W-1:0], i_data[DATA_W-1:NIB_W]};

endmodule

// >>> bench/nibble_swap_and_direction_load_tb_top.sv
`timescale 1ns/1ns
module nibble_swap_and_direction_load_tb_top;
  import nibble_dir_pkg::*;
  logic                      clk, rstn, vld, we, done, ill, we_e, done_e, ill_e;
  logic [INSN_W-1:0]         insn;
  logic [DATA_W-1:0]         rdata, wdata, w, w_e, wd_e;
  logic [FADDR_W-1:0]        addr, ad_e;
  logic [NUM_DIR*DATA_W-1:0] dir, dir_e;
  logic [31:0]               k;
  int                        miscompares, n_checks, seed, i;

  nibble_swap_and_direction_load nibble_swap_and_direction_load_inst (
    .i_clk(clk), .i_rstn(rstn), .i_insn_valid(vld), .i_insn(insn), .i_file_rdata(rdata),
    .o_file_we(we), .o_file_addr(addr), .o_file_wdata(wdata), .o_w(w), .o_dir(dir),
    .o_done(done), .o_illegal(ill));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic final_report;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  function automatic logic [DATA_W-1:0] swapped(input logic [DATA_W-1:0] d);
    return {d[3:0], d[7:4]};
  endfunction

  // Drive one word at the falling edge, model it, check one cycle later
  task automatic step(input logic v, input logic [INSN_W-1:0] in, input logic [DATA_W-1:0] rd);
    vld = v;
    insn = in;
    rdata = rd;
    we_e = 1'b0;
    done_e = 1'b0;
    ill_e = 1'b0;
    if (v && (in & SWAP_MASK) == SWAP_MATCH) begin
      done_e = 1'b1;
      if (in[DEST_BIT]) begin
        we_e = 1'b1;
        ad_e = in[4:0];
        wd_e = swapped(rd);
      end else w_e = swapped(rd);
    end else if (v && (in & DIR_MASK) == DIR_MATCH) begin
      // Old accumulator value is used, it is updated only by a swap
      done_e = 1'b1;
      if (in[2:0] >= DIR_SEL_FIRST) begin
        dir_e[(in[2:0] - 5) * 8 +: 8] = w_e;
      end else ill_e = 1'b1;
    end
    @(negedge clk);
    check("file_we", {31'h0, we}, {31'h0, we_e});
    if (we_e) check("file_addr", {27'h0, addr}, {27'h0, ad_e});
    if (we_e) check("file_wdata", {24'h0, wdata}, {24'h0, wd_e});
    check("w", {24'h0, w}, {24'h0, w_e});
    check("dir", {8'h0, dir}, {8'h0, dir_e});
    check("done", {31'h0, done}, {31'h0, done_e});
    check("illegal", {31'h0, ill}, {31'h0, ill_e});
  endtask

  initial begin
    #20000;
    miscompares++;
    final_report;
  end

  initial begin
    seed = 32'h0000_893f;
    {vld, insn, rdata, rstn} = '0;
    w_e = W_RESET;
    dir_e = {NUM_DIR{DIR_RESET}};
    ad_e = '0;
    wd_e = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    check("w_reset", {24'h0, w}, {24'h0, w_e});
    check("dir_reset", {8'h0, dir}, {8'h0, dir_e});
    step(1'b1, 12'h380, 8'hA5);
    step(1'b1, 12'h006, 8'h00);
    step(1'b1, 12'h3A3, 8'hA5);
    for (i = 0; i < 8; i++) step(1'b1, 12'(i), 8'h3C);
    step(1'b0, 12'h380, 8'hFF);
    repeat (400) begin
      k = $random(seed);
      case (k[1:0])
        2'h1: step(k[16] | k[17], {9'h000, k[4:2]}, k[31:24]);
        2'h2: step(k[16] | k[17], k[15:4], k[31:24]);
        default: step(k[16] | k[17], {6'h0E, k[7:2]}, k[31:24]);
      endcase
    end
    // Reset in mid-run reloads W_RESET and DIR_RESET and clears o_done without waiting for an edge
    vld = 1'b0;
    rstn = 1'b0;
    #1;
    w_e = W_RESET;
    dir_e = {NUM_DIR{DIR_RESET}};
    check("w_mid_reset", {24'h0, w}, {24'h0, w_e});
    check("dir_mid_reset", {8'h0, dir}, {8'h0, dir_e});
    check("done_mid_reset", {31'h0, done}, 32'h0);
    @(negedge clk);
    rstn = 1'b1;
    step(1'b1, 12'h3A3, 8'h1E);
    step(1'b1, 12'h007, 8'h00);
    step(1'b1, 12'h385, 8'hC3);
    step(1'b1, 12'h005, 8'h00);
    final_report;
  end
endmodule
